// file: uvp_pkg.sv
// Purpose: Shared constants and helpers for the three-stage undervoltage protection
// Assumes: Voltages are magnitudes in 0.1 V units; delays count 10 ms ticks
// Notes:   Settings are stored per group and per stage inside the top module
package uvp_pkg;
    localparam int          NSTAGE     = 3;
    localparam int          NGROUP     = 4;
    localparam int          VW         = 16;              // Voltage word width
    localparam int          DW         = 15;              // Delay word width, ticks
    localparam longint      CLK_HZ     = 20000000;
    localparam int          TICK_MS    = 10;              // Delay resolution in ms
    localparam longint      TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
    localparam logic [VW-1:0] UN_DEF   = 16'h03E8;        // Nominal 100.0 V
    // Setting fields on the write port
    localparam logic [2:0]  F_START    = 3'h0;
    localparam logic [2:0]  F_HYST     = 3'h1;
    localparam logic [2:0]  F_BLOCK    = 3'h2;
    localparam logic [2:0]  F_OPDLY    = 3'h3;
    localparam logic [2:0]  F_RELDLY   = 3'h4;
    localparam logic [2:0]  F_ACCZ     = 3'h5;
    // Ranges and reset values, percent, 0.1 percent or ticks
    localparam logic [7:0]  START_MIN  = 8'h14;           // 20 %
    localparam logic [7:0]  START_MAX  = 8'h78;           // 120 %
    localparam logic [7:0]  START_RST  = 8'h50;           // 80 %
    localparam logic [7:0]  HYST_MIN   = 8'h01;           // 1.001
    localparam logic [7:0]  HYST_MAX   = 8'hC8;           // 1.200
    localparam logic [7:0]  HYST_RST   = 8'h1E;           // 1.030
    localparam logic [7:0]  BLK_MAX    = 8'h50;           // 80 %
    localparam logic [DW-1:0] DLY_MAX  = 15'h7530;        // 300.00 s
    localparam logic [DW-1:0] REL_MIN  = 15'h0006;        // 0.06 s
    localparam logic [DW-1:0] OP_MIN1  = 15'h0008;        // 0.08 s
    localparam logic [DW-1:0] OP_MIN2  = 15'h0006;        // 0.06 s
    localparam logic [DW-1:0] OP_MIN3  = 15'h0004;        // 0.04 s
    localparam logic [VW-1:0] BLK_ABS  = 16'h0005;        // 0.5 V margin
    localparam logic [7:0]  BLK_PCT    = 8'h03;           // 3 % margin
    localparam logic [9:0]  PERMILLE   = 10'h3E8;

    typedef enum logic [1:0] {
        UVP_IDLE  = 2'b00,
        UVP_START = 2'b01,
        UVP_TRIP  = 2'b10,
        UVP_HOLD  = 2'b11
    } uvp_state_t;

    // Percent of nominal into voltage units
    function automatic logic [VW-1:0] uvp_pct(input logic [7:0] pct, input logic [VW-1:0] un);
        logic [31:0] p;
        p = 32'(pct) * 32'(un) / 32'd100;
        return p[VW-1:0];
    endfunction : uvp_pct

    // Voltage raised by a per-mille margin, saturating
    function automatic logic [VW-1:0] uvp_raise(input logic [VW-1:0] v, input logic [9:0] pm);
        logic [31:0] p;
        p = 32'(v) * (32'(PERMILLE) + 32'(pm)) / 32'(PERMILLE);
        return (p[31:VW] != '0) ? {VW{1'b1}} : p[VW-1:0];
    endfunction : uvp_raise
endpackage : uvp_pkg

// file: uvp_stage.sv
// Purpose: Definite-time start/trip sequencer of one undervoltage stage
// Assumes: under and recovered are already registered, blocked may not be; tick is a one-cycle pulse
// Notes:   Release delay is only active when rel_en is set
`timescale 1ns/1ps
module uvp_stage
    import uvp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic          under,
    input  wire logic          recovered,
    input  wire logic          blocked,
    input  wire logic          rel_en,
    input  wire logic [DW-1:0] op_ticks,
    input  wire logic [DW-1:0] rel_ticks,
    output logic               start_o,
    output logic               trip_o
);
    uvp_state_t    st_r,  st_nxt;
    logic [DW-1:0] cnt_r, cnt_nxt;

    // Next state; any block or recovery before expiry restarts from zero
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            UVP_IDLE: begin
                cnt_nxt = '0;
                if (under && !blocked) begin
                    st_nxt = UVP_START;
                end
            end
            UVP_START: begin
                if (blocked || recovered) begin
                    st_nxt  = UVP_IDLE;
                    cnt_nxt = '0;
                end else if (cnt_r >= op_ticks) begin
                    st_nxt  = UVP_TRIP;
                    cnt_nxt = '0;
                end else if (tick) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            UVP_TRIP: begin
                cnt_nxt = '0;
                if (blocked) begin
                    st_nxt = UVP_IDLE;
                end else if (recovered) begin
                    st_nxt = (rel_en && rel_ticks != '0) ? UVP_HOLD : UVP_IDLE;
                end
            end
            UVP_HOLD: begin
                // Outputs linger for the release delay; a new dip re-arms the trip
                if (blocked) begin
                    st_nxt  = UVP_IDLE;
                    cnt_nxt = '0;
                end else if (under) begin
                    st_nxt  = UVP_TRIP;
                    cnt_nxt = '0;
                end else if (cnt_r >= rel_ticks) begin
                    st_nxt  = UVP_IDLE;
                    cnt_nxt = '0;
                end else if (tick) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        endcase
    end

    // State register and registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r    <= UVP_IDLE;
            cnt_r   <= '0;
            start_o <= 1'b0;
            trip_o  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            start_o <= (st_nxt != UVP_IDLE);
            trip_o  <= (st_nxt == UVP_TRIP) || (st_nxt == UVP_HOLD);
        end
    end
endmodule : uvp_stage

// file: uvp_top.sv
// Purpose: Three-stage definite-time undervoltage protection with four setting groups
// Assumes: Line-to-line magnitudes arrive synchronous to clk in 0.1 V units
// Notes:   Settings enter through a simple write port; bad writes are refused
`timescale 1ns/1ps
module uvp_top
    import uvp_pkg::*;
#(
    parameter longint          TICK_CYCLES = TICK_CYC,
    parameter logic [VW-1:0]   U_NOMINAL   = UN_DEF
)(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [VW-1:0]     u12,
    input  wire logic [VW-1:0]     u23,
    input  wire logic [VW-1:0]     u31,
    input  wire logic [NSTAGE-1:0] block_in,
    input  wire logic [1:0]        active_group,
    input  wire logic              cfg_we,
    input  wire logic [1:0]        cfg_group,
    input  wire logic [1:0]        cfg_stage,
    input  wire logic [2:0]        cfg_field,
    input  wire logic [DW-1:0]     cfg_data,
    output logic [NSTAGE-1:0]      start,
    output logic [NSTAGE-1:0]      trip,
    output logic                   cfg_err
);
    // Refuse parameters that the 24-bit divider or the percent scaling cannot serve
    if (TICK_CYCLES < 1 || TICK_CYCLES > 32'hFFFFFF || U_NOMINAL == '0) begin : g_bad_param
        $error("uvp_top: unusable tick length or nominal voltage");
    end

    // Divider end count; 24 bits cover the default 10 ms tick with room to spare
    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

    // Setting store, one entry per group and stage
    logic [7:0]    thr_mem_r [NGROUP][NSTAGE];
    logic [7:0]    hys_mem_r [NGROUP][NSTAGE];
    logic [7:0]    blk_mem_r [NGROUP][NSTAGE];
    logic [DW-1:0] op_mem_r  [NGROUP][NSTAGE];
    logic [DW-1:0] rel_mem_r [NGROUP][NSTAGE];
    logic          acz_mem_r [NGROUP][NSTAGE];
    // Write check result and the refusal flag it raises
    logic          wr_ok;
    logic          err_nxt;

    // Smallest operate delay of each stage in ticks; stage three is the quickest
    function automatic logic [DW-1:0] op_min(input int s);
        return (s == 0) ? OP_MIN1 : (s == 1) ? OP_MIN2 : OP_MIN3;
    endfunction : op_min

    // Write check: ranges and step sizes; refused writes leave settings alone
    // Stage and field are checked together so a bad target never lands in storage
    always_comb begin
        wr_ok = 1'b0;
        if (cfg_stage < 2'(NSTAGE)) begin
            unique case (cfg_field)
                F_START:  wr_ok = cfg_data >= 15'(START_MIN) && cfg_data <= 15'(START_MAX);
                F_HYST:   wr_ok = cfg_data >= 15'(HYST_MIN) && cfg_data <= 15'(HYST_MAX);
                F_BLOCK:  wr_ok = cfg_data <= 15'(BLK_MAX);
                F_OPDLY:  wr_ok = cfg_data <= DLY_MAX && (cfg_stage == 2'h2 || !cfg_data[0])
                                  && (cfg_data == '0 || cfg_data >= op_min(int'(cfg_stage)));
                F_RELDLY: wr_ok = cfg_stage == 2'h0 && cfg_data >= REL_MIN
                                  && cfg_data <= DLY_MAX && !cfg_data[0];
                F_ACCZ:   wr_ok = cfg_data <= 15'h0001;
                default:  wr_ok = 1'b0;
            endcase
        end
        err_nxt = cfg_we && !wr_ok;
    end

    // Setting registers; reset loads safe defaults into every group
    // A write to the active group acts on the very next compare, no shadow copy
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int g = 0; g < NGROUP; g++) begin
                for (int s = 0; s < NSTAGE; s++) begin
                    thr_mem_r[g][s] <= START_RST;
                    hys_mem_r[g][s] <= HYST_RST;
                    blk_mem_r[g][s] <= 8'h00;
                    op_mem_r[g][s]  <= op_min(s);
                    rel_mem_r[g][s] <= REL_MIN;
                    acz_mem_r[g][s] <= 1'b0;
                end
            end
            cfg_err <= 1'b0;
        end else begin
            cfg_err <= err_nxt;
            if (cfg_we && wr_ok) begin
                unique case (cfg_field)
                    F_START:  thr_mem_r[cfg_group][cfg_stage] <= cfg_data[7:0];
                    F_HYST:   hys_mem_r[cfg_group][cfg_stage] <= cfg_data[7:0];
                    F_BLOCK:  blk_mem_r[cfg_group][cfg_stage] <= cfg_data[7:0];
                    F_OPDLY:  op_mem_r[cfg_group][cfg_stage]  <= cfg_data;
                    F_RELDLY: rel_mem_r[cfg_group][cfg_stage] <= cfg_data;
                    F_ACCZ:   acz_mem_r[cfg_group][cfg_stage] <= cfg_data[0];
                    default:  ;
                endcase
            end
        end
    end

    // Tick divider: one enable pulse per delay step
    // Delay accuracy is one tick, the price of a single shared counter
    logic [23:0] div_r, div_nxt;
    logic        tick_r, tick_nxt;
    always_comb begin
        tick_nxt = (div_r == TICK_LAST);
        div_nxt  = tick_nxt ? 24'h000000 : div_r + 24'h000001;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            div_r  <= 24'h000000;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // Smallest and largest line voltage, registered to cut the compare path
    // All ones at reset so no stage sees a dip before real samples arrive
    logic [VW-1:0] vmin_r, vmin_nxt, vmax_r, vmax_nxt;
    always_comb begin
        vmin_nxt = (u12 < u23) ? u12 : u23;
        vmin_nxt = (u31 < vmin_nxt) ? u31 : vmin_nxt;
        vmax_nxt = (u12 > u23) ? u12 : u23;
        vmax_nxt = (u31 > vmax_nxt) ? u31 : vmax_nxt;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            vmin_r <= {VW{1'b1}};
            vmax_r <= {VW{1'b1}};
        end else begin
            vmin_r <= vmin_nxt;
            vmax_r <= vmax_nxt;
        end
    end

    // Per-stage level detection and self-block with its own release margin
    // Margins are worked out every cycle so a group switch applies at once
    logic [NSTAGE-1:0] under_r, under_nxt, recov_r, recov_nxt;
    logic [NSTAGE-1:0] lowblk_r, lowblk_nxt, blocked;
    logic [DW-1:0]     op_eff [NSTAGE];
    logic [DW-1:0]     rel_eff [NSTAGE];
    always_comb begin
        logic [VW-1:0] thr, rthr, lim, lrel, lpct;
        thr = '0; rthr = '0; lim = '0; lrel = '0; lpct = '0;
        for (int s = 0; s < NSTAGE; s++) begin
            thr  = uvp_pct(thr_mem_r[active_group][s], U_NOMINAL);
            rthr = uvp_raise(thr, 10'(hys_mem_r[active_group][s]));
            lim  = uvp_pct(blk_mem_r[active_group][s], U_NOMINAL);
            lpct = uvp_raise(lim, 10'(BLK_PCT) * 10'd10);
            lrel = lim + BLK_ABS;
            lrel = (lpct > lrel) ? lpct : lrel;
            under_nxt[s] = vmin_r < thr;
            recov_nxt[s] = vmin_r >= rthr;
            if (lim == '0) begin
                lowblk_nxt[s] = 1'b0;
            end else if (vmax_r < lim) begin
                lowblk_nxt[s] = 1'b1;
            end else if (vmax_r > lrel) begin
                lowblk_nxt[s] = 1'b0;
            end else begin
                lowblk_nxt[s] = lowblk_r[s];
            end
            // Block input goes unregistered to the stage so a block lands within one clock
            blocked[s] = block_in[s] || lowblk_r[s];
            // Zero delay only counts when accepted; otherwise the stage minimum holds
            op_eff[s] = (op_mem_r[active_group][s] == '0 && !acz_mem_r[active_group][s])
                        ? op_min(s) : op_mem_r[active_group][s];
            rel_eff[s] = rel_mem_r[active_group][s];
        end
    end
    // Recovered resets high so no stage can start from stale flags
    always_ff @(posedge clk) begin
        if (rst) begin
            under_r  <= '0;
            recov_r  <= '1;
            lowblk_r <= '0;
        end else begin
            under_r  <= under_nxt;
            recov_r  <= recov_nxt;
            lowblk_r <= lowblk_nxt;
        end
    end

    // Three independent definite-time sequencers
    // Only stage one gets a release delay; the others drop as soon as the line recovers
    for (genvar s = 0; s < NSTAGE; s++) begin : g_stage
        uvp_stage u_stage (
            .clk       (clk),
            .rst       (rst),
            .tick      (tick_r),
            .under     (under_r[s]),
            .recovered (recov_r[s]),
            .blocked   (blocked[s]),
            .rel_en    (s == 0),
            .op_ticks  (op_eff[s]),
            .rel_ticks (rel_eff[s]),
            .start_o   (start[s]),
            .trip_o    (trip[s])
        );
    end
endmodule : uvp_top

// file: uvp_top_assertions.sv
// Purpose: Port-level checks of the three-stage undervoltage protection
// Assumes: One clock domain, synchronous active-high reset
// Notes:   LIM is the highest legal start level; nothing may start above it
`timescale 1ns/1ps
module uvp_chk
    import uvp_pkg::*;
#(
    parameter logic [VW-1:0] U_NOMINAL = UN_DEF
)(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [VW-1:0]     u12,
    input wire logic [VW-1:0]     u23,
    input wire logic [VW-1:0]     u31,
    input wire logic [NSTAGE-1:0] block_in,
    input wire logic [1:0]        active_group,
    input wire logic              cfg_we,
    input wire logic [1:0]        cfg_group,
    input wire logic [1:0]        cfg_stage,
    input wire logic [2:0]        cfg_field,
    input wire logic [DW-1:0]     cfg_data,
    input wire logic [NSTAGE-1:0] start,
    input wire logic [NSTAGE-1:0] trip,
    input wire logic              cfg_err
);
    localparam logic [31:0] LIM = 32'(U_NOMINAL) * 32'd120 / 32'd100;
    logic low_any;
    logic wr_ok;
    // Any line below the top threshold, and a write aimed at a real stage
    assign low_any = (32'(u12) < LIM) || (32'(u23) < LIM) || (32'(u31) < LIM);
    assign wr_ok = cfg_we && (cfg_stage != 2'h3);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_start_cause;
        ((start & ~$past(start)) != 3'h0) |-> $past(low_any, 3);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start rose without a low line voltage");
    property p_trip_cause;
        (trip & ~$past(trip) & ~$past(start)) == 3'h0;
    endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip rose without a prior start");
    property p_block;
        (block_in != 3'h0) |=> (((start | trip) & $past(block_in)) == 3'h0);
    endproperty
    a_block: assert property (p_block) else $error("output active one cycle after block");
    property p_trip_start;
        (trip & ~start) == 3'h0;
    endproperty
    a_trip_start: assert property (p_trip_start) else $error("trip without start");
    property p_drop;
        (~trip & $past(trip) & start) == 3'h0;
    endproperty
    a_drop: assert property (p_drop) else $error("trip fell while start stayed");
    property p_start_ok;
        (wr_ok && cfg_field == F_START && cfg_data >= 15'h0014 && cfg_data <= 15'h0078) |=> !cfg_err;
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("legal start level refused");
    property p_hyst;
        (wr_ok && cfg_field == F_HYST && (cfg_data == 15'h0000 || cfg_data > 15'h00C8)) |=> cfg_err;
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis out of range accepted");
    property p_op_step;
        (cfg_we && cfg_stage < 2'h2 && cfg_field == F_OPDLY && cfg_data[0]) |=> cfg_err;
    endproperty
    a_op_step: assert property (p_op_step) else $error("odd delay accepted on stage one or two");
endmodule : uvp_chk

bind uvp_top uvp_chk #(.U_NOMINAL(U_NOMINAL)) u_uvp_chk (.clk(clk), .rst(rst), .u12(u12), .u23(u23), .u31(u31),
    .block_in(block_in), .active_group(active_group), .cfg_we(cfg_we), .cfg_group(cfg_group),
    .cfg_stage(cfg_stage), .cfg_field(cfg_field), .cfg_data(cfg_data), .start(start), .trip(trip),
    .cfg_err(cfg_err));

// file: uvp_meas_model.sv
// Purpose: Behavioural voltage measurement chain feeding line-to-line magnitudes
// Assumes: Bench sets the smallest and largest magnitude and which line is lowest
// Notes:   Third line sits halfway, so min and max are exactly what the bench set
`timescale 1ns/1ps
module uvp_meas_model
    import uvp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic [VW-1:0] vlo,
    input  wire logic [VW-1:0] vhi,
    input  wire logic [1:0]    rot,
    output logic      [VW-1:0] u12 = 16'h03E8,
    output logic      [VW-1:0] u23 = 16'h03E8,
    output logic      [VW-1:0] u31 = 16'h03E8
);
    logic [VW-1:0] mid;
    assign mid = VW'((17'(vlo) + 17'(vhi)) >> 1);
    // One update per clock; rotating the dip proves no line is favoured
    always @(posedge clk) begin
        u12 <= (rot == 2'h0) ? vlo : (rot == 2'h1) ? vhi : mid;
        u23 <= (rot == 2'h1) ? vlo : rot[1] ? vhi : mid;
        u31 <= rot[1] ? vlo : (rot == 2'h0) ? vhi : mid;
    end
endmodule : uvp_meas_model

// file: tb_undervoltage_protection_stage.sv
// Purpose: Self-checking bench for the three-stage undervoltage protection
// Assumes: Tick shortened to TC clocks; nominal 100.0 V in 0.1 V units
// Notes:   Random writes go to group 3 only, so the groups under test stay known
`timescale 1ns/1ps
module tb_undervoltage_protection_stage;
    import uvp_pkg::*;
    localparam int TC = 4;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [VW-1:0]     vlo = 16'h03E8;
    logic [VW-1:0]     vhi = 16'h03E8;
    logic [1:0]        rot = 2'h0;
    logic [VW-1:0]     u12, u23, u31;
    logic [NSTAGE-1:0] block_in = 3'h0;
    logic [1:0]        active_group = 2'h0;
    logic              cfg_we = 1'b0;
    logic [1:0]        cfg_group = 2'h0;
    logic [1:0]        cfg_stage = 2'h0;
    logic [2:0]        cfg_field = 3'h0;
    logic [DW-1:0]     cfg_data = 15'h0000;
    logic [NSTAGE-1:0] start, trip;
    logic              cfg_err;
    logic [31:0]       lfsr = 32'd32718;
    int                err_total = 0;
    int                tests_run = 0;
    int                n;
    // Corner writes: {stage, field, value}
    localparam logic [19:0] CRN [15] = '{{2'h0, 3'h0, 15'h0013}, {2'h0, 3'h0, 15'h0014}, {2'h0, 3'h0, 15'h0078},
        {2'h0, 3'h0, 15'h0079}, {2'h1, 3'h1, 15'h0000}, {2'h1, 3'h1, 15'h00C8}, {2'h1, 3'h1, 15'h00C9},
        {2'h2, 3'h2, 15'h0050}, {2'h2, 3'h2, 15'h0051}, {2'h0, 3'h3, 15'h0009}, {2'h0, 3'h3, 15'h7532},
        {2'h2, 3'h3, 15'h0003}, {2'h1, 3'h4, 15'h0006}, {2'h0, 3'h5, 15'h0002}, {2'h3, 3'h7, 15'h0001}};

    always #25 clk = ~clk;

    uvp_meas_model u_uvp_meas_model (.clk(clk), .vlo(vlo), .vhi(vhi), .rot(rot), .u12(u12), .u23(u23), .u31(u31));
    uvp_top #(.TICK_CYCLES(TC)) u_uvp_top (.clk(clk), .rst(rst), .u12(u12), .u23(u23), .u31(u31),
        .block_in(block_in), .active_group(active_group), .cfg_we(cfg_we), .cfg_group(cfg_group),
        .cfg_stage(cfg_stage), .cfg_field(cfg_field), .cfg_data(cfg_data), .start(start), .trip(trip),
        .cfg_err(cfg_err));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Whether a write must be refused, from the setting ranges
    function automatic logic bad_wr(input logic [1:0] s, input logic [2:0] f, input logic [DW-1:0] d);
        logic [DW-1:0] mn;
        mn = (s == 2'h0) ? 15'h0008 : (s == 2'h1) ? 15'h0006 : 15'h0004;
        if (s == 2'h3 || f > 3'h5) return 1'b1;
        case (f)
            3'h0: return d < 15'h0014 || d > 15'h0078;
            3'h1: return d == 15'h0000 || d > 15'h00C8;
            3'h2: return d > 15'h0050;
            3'h3: return d > 15'h7530 || (s != 2'h2 && d[0]) || (d != 15'h0000 && d < mn);
            3'h4: return s != 2'h0 || d < 15'h0006 || d > 15'h7530 || d[0];
            default: return d > 15'h0001;
        endcase
    endfunction : bad_wr
    task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_out
    task automatic chk_err(input logic got, input logic exp);
        chk_out({2'h0, got}, {2'h0, exp});
    endtask : chk_err
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // One write; the answer is looked at in the cycle after it, when the registered cfg_err shows it
    task automatic wr(input logic [1:0] g, input logic [1:0] s, input logic [2:0] f, input logic [DW-1:0] d);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_group <= g;
        cfg_stage <= s;
        cfg_field <= f;
        cfg_data <= d;
        @(posedge clk);
        cfg_we <= 1'b0;
        #1;
        chk_err(cfg_err, bad_wr(s, f, d));
    endtask : wr
    task automatic drive(input logic [VW-1:0] lo, input logic [VW-1:0] hi, input logic [2:0] b, input logic [1:0] g);
        @(posedge clk);
        vlo <= lo;
        vhi <= hi;
        block_in <= b;
        active_group <= g;
        #1;
    endtask : drive
    // Bounded wait until the selected outputs reach a level
    task automatic wait_out(input logic tr, input logic [2:0] m, input logic lvl, input int hi, output int c);
        c = 0;
        while ((((tr ? trip : start) & m) != (lvl ? m : 3'h0)) && c < hi) begin
            @(posedge clk);
            #1;
            c++;
        end
        chk_out((tr ? trip : start) & m, lvl ? m : 3'h0);
    endtask : wait_out

    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_out(start | trip, 3'h0);
        for (int i = 0; i < 40; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            vlo <= 16'(lfsr[10:0]);
            vhi <= 16'(lfsr[21:11]);
            rot <= lfsr[23:22];
            wr(2'h3, lfsr[25:24], lfsr[28:26], lfsr[29] ? lfsr[14:0] : 15'(lfsr[7:0]));
        end
        foreach (CRN[i]) wr(2'h3, CRN[i][19:18], CRN[i][17:15], CRN[i][14:0]);
        drive(16'h03E8, 16'h03E8, 3'h0, 2'h0);
        wait_out(1'b0, 3'h7, 1'b0, 10 * TC, n);
        wr(2'h0, 2'h1, F_START, 15'h003C);
        wr(2'h0, 2'h1, F_BLOCK, 15'h0032);
        wr(2'h0, 2'h2, F_BLOCK, 15'h000F);
        wr(2'h2, 2'h2, F_BLOCK, 15'h000F);
        wr(2'h0, 2'h0, F_HYST, 15'h0032);
        wr(2'h0, 2'h0, F_RELDLY, 15'h0008);
        wr(2'h0, 2'h2, F_START, 15'h005A);
        wr(2'h1, 2'h0, F_START, 15'h0014);
        wr(2'h2, 2'h2, F_ACCZ, 15'h0001);
        wr(2'h2, 2'h2, F_OPDLY, 15'h0000);
        // Stage one: start, timed trip, hysteresis band, release hold
        drive(16'h02BC, 16'h03E8, 3'h6, 2'h0);
        wait_out(1'b0, 3'h1, 1'b1, 6, n);
        wait_out(1'b1, 3'h1, 1'b1, 9 * TC + 4, n);
        chk_err(n >= 7 * TC, 1'b1);
        drive(16'h033E, 16'h03E8, 3'h6, 2'h0);
        repeat (8) @(posedge clk);
        #1;
        chk_out(start & trip & 3'h1, 3'h1);
        drive(16'h0352, 16'h03E8, 3'h6, 2'h0);
        repeat (4 * TC) @(posedge clk);
        #1;
        chk_out(trip & 3'h1, 3'h1);
        wait_out(1'b0, 3'h1, 1'b0, 4 * TC + 6, n);
        chk_err(n >= 4 * TC, 1'b1);
        chk_out(trip, 3'h0);
        // Stage three: block in mid-timer restarts the delay
        drive(16'h0352, 16'h03E8, 3'h3, 2'h0);
        wait_out(1'b0, 3'h4, 1'b1, 6, n);
        repeat (2 * TC) @(posedge clk);
        drive(16'h0352, 16'h03E8, 3'h7, 2'h0);
        @(posedge clk);
        #1;
        chk_out(start | trip, 3'h0);
        drive(16'h0352, 16'h03E8, 3'h3, 2'h0);
        wait_out(1'b0, 3'h4, 1'b1, 4, n);
        wait_out(1'b1, 3'h4, 1'b1, 5 * TC + 4, n);
        chk_err(n >= 3 * TC, 1'b1);
        drive(16'h03E8, 16'h03E8, 3'h3, 2'h0);
        wait_out(1'b0, 3'h4, 1'b0, 6, n);
        chk_out(trip, 3'h0);
        // Self-block on stage two; stage one with zero limit is not blocked
        drive(16'h0190, 16'h0190, 3'h4, 2'h0);
        wait_out(1'b0, 3'h1, 1'b1, 6, n);
        repeat (6) @(posedge clk);
        #1;
        chk_out(start & 3'h2, 3'h0);
        drive(16'h0190, 16'h01FE, 3'h4, 2'h0);
        repeat (6) @(posedge clk);
        #1;
        chk_out(start & 3'h2, 3'h0);
        drive(16'h0190, 16'h0208, 3'h4, 2'h0);
        wait_out(1'b0, 3'h2, 1'b1, 6, n);
        drive(16'h03E8, 16'h03E8, 3'h0, 2'h0);
        wait_out(1'b0, 3'h7, 1'b0, 10 * TC, n);
        // Setting groups: group 1 stage one starts only below 20 %
        drive(16'h01F4, 16'h03E8, 3'h6, 2'h1);
        repeat (8) @(posedge clk);
        #1;
        chk_out(start & 3'h1, 3'h0);
        drive(16'h01F4, 16'h03E8, 3'h6, 2'h0);
        wait_out(1'b0, 3'h1, 1'b1, 6, n);
        drive(16'h03E8, 16'h03E8, 3'h6, 2'h0);
        wait_out(1'b0, 3'h7, 1'b0, 10 * TC, n);
        // Group 2 stage three with accepted zero delay trips at once
        drive(16'h02BC, 16'h03E8, 3'h3, 2'h2);
        wait_out(1'b0, 3'h4, 1'b1, 6, n);
        wait_out(1'b1, 3'h4, 1'b1, 2, n);
        give_verdict();
    end
endmodule : tb_undervoltage_protection_stage
